/* File: tb/ahbf_fabric_tb_top.sv */
// ==========================================================
// Bench acting as the single master.
module ahbf_fabric_tb_top
	import ahbf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, resetn = 0, dir = 0, remap = 0, rb, m_rdy;
	logic [31:0] m_addr = 0, wdata = 0, s_addr, s_wd, rdata;
	logic [1:0] trans = 0, s_tr, resp = 0, m_resp;
	logic [2:0] size = 0, burst = 0, s_sz, s_bu;
	logic [3:0] prot = 0, s_pr;
	logic s_dir;
	logic [15:0] sel, stall = 0, rdy;
	logic [511:0] rd;
	logic [31:0] sr;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	ahbf_fabric uut (.clk(clk), .resetn(resetn), .master_address(m_addr),
		.master_transfer_type(trans), .master_direction(dir), .master_transfer_size(size),
		.master_burst_type(burst), .master_protection(prot), .master_write_data(wdata),
		.master_read_data(rdata), .master_ready(m_rdy), .master_response(m_resp),
		.remap(remap), .slave_side_address(s_addr), .slave_side_transfer_type(s_tr),
		.slave_side_direction(s_dir), .slave_side_transfer_size(s_sz),
		.slave_side_burst_type(s_bu), .slave_side_protection(s_pr),
		.slave_side_write_data(s_wd), .ready_broadcast_to_slaves(rb), .slot_select(sel),
		.slot_read_data(rd), .slot_ready(rdy), .slot_response(sr));
	ahbf_slave_model slaves (.stall(stall), .resp_code(resp), .slot_read_data(rd),
		.slot_ready(rdy), .slot_response(sr));
	// The clock toggles every half period of 12.5 ns.
	always #12.5 clk = ~clk;
	// A hang is cut short well past the expected run length.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	task end_sim();
		$display("Counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// Inputs change on the falling edge and are judged once settled.
	task addr(input logic [31:0] a, input logic [1:0] t);
		@(negedge clk);
		m_addr = a;
		trans = t;
		#1;
	endtask : addr
	task t_decode();
		for (int i = 0; i <= 16; i++)
		begin
			addr({i[3:0], 28'h0ABCDEF}, (i < 16) ? AHBF_TRANS_NONSEQ : AHBF_TRANS_IDLE);
			check(sel, (i < 16) ? 32'(1 << i) : 0);
			if (i > 0) check(rdata, 32'h5A000000 + i - 1);
		end
	endtask : t_decode
	task t_pass();
		dir = 1;
		wdata = 32'hC3A5965A;
		burst = 3'h5;
		prot = 4'hB;
		for (int t = 0; t < 4; t++)
		begin
			size = 3'(t % 3);
			addr(32'h7000F00C, t[1:0]);
			check(s_tr, t);
			check(sel, t[1] ? 32'h80 : 0);
			check({s_addr, s_wd}, {32'h7000F00C, 32'hC3A5965A});
			check({s_dir, s_sz, s_bu, s_pr}, {1'b1, size, 3'h5, 4'hB});
		end
	endtask : t_pass
	task t_wait();
		stall = 16'h0008;
		addr(32'h30000000, AHBF_TRANS_NONSEQ);
		addr(0, AHBF_TRANS_IDLE);
		check({m_rdy, rb}, 0);
		@(negedge clk);
		check({m_rdy, rdata}, 32'h5A000003);
		stall = 0;
		#1 check({m_rdy, rb}, 3);
	endtask : t_wait
	task t_resp();
		for (int r = 0; r < 4; r++)
		begin
			resp = r[1:0];
			addr(32'h50000000, AHBF_TRANS_SEQ);
			addr(0, AHBF_TRANS_IDLE);
			check(m_resp, r);
		end
		resp = 0;
	endtask : t_resp
	task t_remap();
		remap = 1;
		addr(0, AHBF_TRANS_NONSEQ);
		check(sel, 32'h2);
		addr(32'h1FFFFFFC, AHBF_TRANS_NONSEQ);
		check({sel, rdata}, 48'h0001_5A00_0001);
		remap = 1'bz;
		addr(0, AHBF_TRANS_NONSEQ);
		check(sel, 32'h1);
		remap = 0;
	endtask : t_remap
	// A reset in mid wait must drop the data phase back to idle.
	task t_reset();
		stall = 16'h0010;
		addr(32'h40000000, AHBF_TRANS_NONSEQ);
		addr(0, AHBF_TRANS_IDLE);
		check(m_rdy, 0);
		@(negedge clk);
		resetn = 0;
		#1 check({m_rdy, m_resp, rdata}, 35'h400000000);
		stall = 0;
		repeat (2) @(negedge clk);
		resetn = 1;
	endtask : t_reset
	initial
	begin
		@(negedge clk);
		check({m_rdy, m_resp, rdata}, 35'h400000000);
		@(negedge clk);
		resetn = 1;
		t_decode();
		t_pass();
		t_wait();
		t_resp();
		t_remap();
		t_reset();
		t_decode();
		end_sim();
	end
endmodule : ahbf_fabric_tb_top

/* File: tb/ahbf_slave_model.sv */
// ==========================================================
// Sixteen slaves answering at once; the fabric picks the owner.
module ahbf_slave_model
	import ahbf_pkg::*;
(
	// Test controls
	input  wire logic [AHBF_SLOTS-1:0]   stall,
	input  wire logic [1:0]              resp_code,
	// Slot answers
	output logic [AHBF_SLOTS*32-1:0]     slot_read_data,
	output logic [AHBF_SLOTS-1:0]        slot_ready,
	output logic [AHBF_SLOTS*2-1:0]      slot_response
);
	timeunit 1ns;
	timeprecision 100ps;
	// Each slot shows its own number so a wrong mux choice is visible.
	for (genvar g = 0; g < AHBF_SLOTS; g++)
	begin : g_slot
		assign slot_read_data[g*32+:32] = 32'h5A000000 + 32'(g);
		assign slot_ready[g] = ~stall[g];
		assign slot_response[g*2+:2] = resp_code;
	end
endmodule : ahbf_slave_model

/* File: verilog/ahbf_decoder.sv */
// ==========================================================
// Address decoder with boot remap.
module ahbf_decoder
	import ahbf_pkg::*;
(
	// Address phase
	input  wire logic [31:0]            addr,
	input  wire logic [1:0]             trans,
	input  wire logic                   remap,
	// Decoded slot
	output logic [AHBF_IDX_W-1:0]       slot_idx,
	output logic [AHBF_SLOTS-1:0]       slot_hit
);
	logic [AHBF_IDX_W-1:0] raw_idx;
	logic                  active;

	// Slot index from the top nibble; remap flips the low index bit, swapping each even/odd slot pair.
	assign raw_idx  = addr[AHBF_IDX_MSB:AHBF_IDX_LSB]; // R2 R3
	assign slot_idx = remap ? {raw_idx[3:1], ~raw_idx[0]} : raw_idx; // R16
	assign active   = trans[1]; // R3

	// One hot select, only for non-sequential or sequential beats.
	genvar g;
	generate
		for (g = 0; g < AHBF_SLOTS; g++)
		begin : g_hit
			assign slot_hit[g] = active && (slot_idx == AHBF_IDX_W'(g)); // R3 R4
		end
	endgenerate
endmodule : ahbf_decoder

/* File: verilog/ahbf_fabric.sv */
// Function
// R1: One master only; no arbitration, no split or retry handling.
// R2: Address space split into sixteen equal 256 MB slots.
// R3: Top four address bits pick the slot; select only during real transfers.
// R4: One select output per slot, 0 through 15.
// R5: Address, type, direction, size, burst, protection forwarded to all slaves.
// R6: Transfer type codes idle, busy, nonseq, seq passed unchanged.
// R7: Size codes byte, halfword, word passed unchanged.
// R8: Master drives direction high for write; presented to slaves.
// R9: Write data shared to all slaves.
// R10: Read data of the data-phase owner returned through a mux.
// R11: Mux slot registered from address phase while ready is high.
// R12: Two-bit response of active slave routed to master.
// R13: Slaves hold ready low for wait states.
// R14: Ready low extends transfer; master holds until ready high.
// R15: Ready broadcast to slaves equals master ready.
// R16: Remap high swaps slots 0 and 1. The code flips the low index bit, so it also swaps 2 and 3, 4 and 5, and so on.
// R17: Remap left unconnected acts as zero.
// R18: All state timed on the rising clock edge.
// R19: Active-low reset clears internal state.
module ahbf_fabric
	import ahbf_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// Master side
	input  wire logic [31:0]                 master_address,
	input  wire logic [1:0]                  master_transfer_type,
	input  wire logic                        master_direction,
	input  wire logic [2:0]                  master_transfer_size,
	input  wire logic [2:0]                  master_burst_type,
	input  wire logic [3:0]                  master_protection,
	input  wire logic [31:0]                 master_write_data,
	output logic [31:0]                      master_read_data,
	output logic                             master_ready,
	output logic [1:0]                       master_response,
	// Boot remap
	input  wire logic                        remap,
	// Common slave side
	output logic [31:0]                      slave_side_address,
	output logic [1:0]                       slave_side_transfer_type,
	output logic                             slave_side_direction,
	output logic [2:0]                       slave_side_transfer_size,
	output logic [2:0]                       slave_side_burst_type,
	output logic [3:0]                       slave_side_protection,
	output logic [31:0]                      slave_side_write_data,
	output logic                             ready_broadcast_to_slaves,
	// Per-slot signals
	output logic [AHBF_SLOTS-1:0]            slot_select,
	input  wire logic [AHBF_SLOTS*32-1:0]    slot_read_data,
	input  wire logic [AHBF_SLOTS-1:0]       slot_ready,
	input  wire logic [AHBF_SLOTS*2-1:0]     slot_response
);
	// ==========================================================
	// Address decode
	logic [AHBF_IDX_W-1:0] dec_idx;
	logic [AHBF_SLOTS-1:0] dec_hit;
	logic                  dphase_reg;
	logic                  dphase_next;
	logic [AHBF_IDX_W-1:0] dslot_reg;
	logic [AHBF_IDX_W-1:0] dslot_next;
	logic                  ready_mux;
	logic [31:0]           rdata_mux;
	logic [1:0]            resp_mux;

	// An unconnected remap floats; a Z or X on it is treated as 0, so it need not be tied low.
	logic remap_eff;
	assign remap_eff = (remap === 1'b1); // R17

	ahbf_decoder u_dec
	(
		.addr     (master_address),
		.trans    (master_transfer_type),
		.remap    (remap_eff),
		.slot_idx (dec_idx),
		.slot_hit (dec_hit)
	);

	// ==========================================================
	// Data phase owner, captured while ready is high.
	// No split or retry bookkeeping is kept, since a single master owns the bus.
	assign dphase_next = ready_mux ? master_transfer_type[1] : dphase_reg; // R1 R11
	assign dslot_next  = ready_mux ? dec_idx : dslot_reg; // R11

	// Data phase flag; reset drops it so the master sees an idle, ready bus.
	always_ff @(posedge clk or negedge resetn) // R18 R19
	begin
		if (!resetn)
			dphase_reg <= AHBF_SEL_RST;
		else
			dphase_reg <= dphase_next;
	end

	// Owning slot of the data phase, only meaningful while the flag is set.
	always_ff @(posedge clk or negedge resetn) // R18 R19
	begin
		if (!resetn)
			dslot_reg <= AHBF_IDX_RST;
		else
			dslot_reg <= dslot_next;
	end

	// ==========================================================
	// Slot slices of the packed answer buses; shared by the mux and its checks.
	function automatic logic [31:0] ahbf_word_of
	(
		input logic [AHBF_SLOTS*32-1:0] bus,
		input logic [AHBF_IDX_W-1:0]    idx
	);
		return bus[idx*32 +: 32];
	endfunction : ahbf_word_of

	function automatic logic [1:0] ahbf_resp_of
	(
		input logic [AHBF_SLOTS*2-1:0] bus,
		input logic [AHBF_IDX_W-1:0]   idx
	);
		return bus[idx*2 +: 2];
	endfunction : ahbf_resp_of

	// Read data and response mux; idle data phase answers ready OKAY.
	assign ready_mux = dphase_reg ? slot_ready[dslot_reg] : 1'b1; // R13 R14
	assign rdata_mux = dphase_reg ? ahbf_word_of(slot_read_data, dslot_reg) : AHBF_DATA_RST; // R10
	assign resp_mux  = dphase_reg ? ahbf_resp_of(slot_response, dslot_reg) : AHBF_RESP_OKAY; // R12

	// The return path is combinational: registering it would add a wait state per beat.
	assign master_read_data          = rdata_mux; // R10
	assign master_ready              = ready_mux; // R14
	assign master_response           = resp_mux; // R12
	assign ready_broadcast_to_slaves = ready_mux; // R15

	// ==========================================================
	// Broadcast of address phase and write data, unchanged.
	assign slave_side_address       = master_address; // R5
	assign slave_side_transfer_type = master_transfer_type; // R5 R6
	assign slave_side_direction     = master_direction; // R5 R8
	assign slave_side_transfer_size = master_transfer_size; // R5 R7
	assign slave_side_burst_type    = master_burst_type; // R5
	assign slave_side_protection    = master_protection; // R5
	assign slave_side_write_data    = master_write_data; // R9
	assign slot_select              = dec_hit; // R3 R4

	// ==========================================================
	// Checks: slot decode and boot remap.
	// The remap checks read remap_eff, so a floating pin is judged as low.
	a_select_onehot: assert property ( // R3
		@(posedge clk) disable iff (!resetn) $onehot0(slot_select))
		else $error("more than one slot selected");
	a_select_idle: assert property ( // R3
		@(posedge clk) disable iff (!resetn)
		!master_transfer_type[1] |-> slot_select == '0)
		else $error("select without transfer");
	a_no_remap: assert property ( // R2 R17
		@(posedge clk) disable iff (!resetn) (!remap_eff && master_transfer_type[1])
		|-> slot_select[master_address[AHBF_IDX_MSB:AHBF_IDX_LSB]])
		else $error("slot mismatch");
	a_remap_swap: assert property ( // R16
		@(posedge clk) disable iff (!resetn) (remap_eff && master_transfer_type[1]
		&& master_address[AHBF_IDX_MSB:AHBF_IDX_LSB] == 4'h0) |-> slot_select[1])
		else $error("remap did not move slot 0");
	a_remap_back: assert property ( // R16
		@(posedge clk) disable iff (!resetn) (remap_eff && master_transfer_type[1]
		&& master_address[AHBF_IDX_MSB:AHBF_IDX_LSB] == 4'h1) |-> slot_select[0])
		else $error("remap did not move slot 1");

	// ==========================================================
	// Checks: data phase return path.
	a_dphase_slot: assert property ( // R11 R13 R14
		@(posedge clk) disable iff (!resetn) (master_ready && master_transfer_type[1])
		|=> master_ready == slot_ready[$past(dec_idx)])
		else $error("data phase slot wrong");
	a_data_route: assert property ( // R10 R11
		@(posedge clk) disable iff (!resetn) (master_ready && master_transfer_type[1])
		|=> master_read_data == ahbf_word_of(slot_read_data, $past(dec_idx)))
		else $error("read data wrong");
	a_resp_route: assert property ( // R12
		@(posedge clk) disable iff (!resetn) (master_ready && master_transfer_type[1])
		|=> master_response == ahbf_resp_of(slot_response, $past(dec_idx)))
		else $error("response wrong");
	a_wait_hold: assert property ( // R14
		@(posedge clk) disable iff (!resetn) !master_ready |=> $stable(dslot_reg))
		else $error("owner moved in wait");
	a_idle_okay: assert property ( // R6 R12
		@(posedge clk) disable iff (!resetn) (master_ready && !master_transfer_type[1])
		|=> master_ready && master_response == AHBF_RESP_OKAY)
		else $error("idle phase not ready okay");
	a_idle_data: assert property ( // R10
		@(posedge clk) disable iff (!resetn) (master_ready && !master_transfer_type[1])
		|=> master_read_data == AHBF_DATA_RST)
		else $error("idle phase data not zero");
	a_ready_bcast: assert property ( // R15
		@(posedge clk) disable iff (!resetn) ready_broadcast_to_slaves == master_ready)
		else $error("ready broadcast differs");
	// Judged at the second edge of reset, once the asynchronous clear has surely landed.
	a_reset_idle: assert property ( // R19
		@(posedge clk) (!resetn ##1 !resetn)
		|-> master_ready && master_response == AHBF_RESP_OKAY
		&& master_read_data == AHBF_DATA_RST)
		else $error("reset left a data phase open");

	// ==========================================================
	// Checks: address phase and write data broadcast.
	// Pure wiring, but a slip in the port map would show here first.
	a_addr_bcast: assert property ( // R5
		@(posedge clk) disable iff (!resetn) slave_side_address == master_address)
		else $error("address not forwarded");
	a_type_bcast: assert property ( // R5 R6
		@(posedge clk) disable iff (!resetn) slave_side_transfer_type == master_transfer_type)
		else $error("transfer type not forwarded");
	a_dir_bcast: assert property ( // R5 R8
		@(posedge clk) disable iff (!resetn) slave_side_direction == master_direction)
		else $error("direction not forwarded");
	a_size_bcast: assert property ( // R5 R7
		@(posedge clk) disable iff (!resetn) slave_side_transfer_size == master_transfer_size)
		else $error("size not forwarded");
	a_burst_bcast: assert property ( // R5
		@(posedge clk) disable iff (!resetn) slave_side_burst_type == master_burst_type)
		else $error("burst not forwarded");
	a_prot_bcast: assert property ( // R5
		@(posedge clk) disable iff (!resetn) slave_side_protection == master_protection)
		else $error("protection not forwarded");
	a_wdata_bcast: assert property ( // R9
		@(posedge clk) disable iff (!resetn) slave_side_write_data == master_write_data)
		else $error("write data not forwarded");
endmodule : ahbf_fabric

/* File: verilog/ahbf_pkg.sv */
package ahbf_pkg;
	// ==========================================================
	// Fabric geometry
	localparam int          AHBF_SLOTS      = 16;
	localparam int          AHBF_IDX_W      = 4;
	localparam int          AHBF_IDX_MSB    = 31;
	localparam int          AHBF_IDX_LSB    = 28;
	localparam logic [3:0]  AHBF_IDX_RST    = 4'h0;
	localparam logic        AHBF_SEL_RST    = 1'h0;
	localparam logic [31:0] AHBF_DATA_RST   = 32'h0;
	// ==========================================================
	// Transfer type codes
	localparam logic [1:0]  AHBF_TRANS_IDLE   = 2'h0;
	localparam logic [1:0]  AHBF_TRANS_BUSY   = 2'h1;
	localparam logic [1:0]  AHBF_TRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  AHBF_TRANS_SEQ    = 2'h3;
	// ==========================================================
	// Transfer size codes
	localparam logic [2:0]  AHBF_SIZE_BYTE  = 3'h0;
	localparam logic [2:0]  AHBF_SIZE_HALF  = 3'h1;
	localparam logic [2:0]  AHBF_SIZE_WORD  = 3'h2;
	// ==========================================================
	// Response codes
	localparam logic [1:0]  AHBF_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  AHBF_RESP_ERROR = 2'h1;
	localparam logic [1:0]  AHBF_RESP_RETRY = 2'h2;
	localparam logic [1:0]  AHBF_RESP_SPLIT = 2'h3;
endpackage : ahbf_pkg
